// ==== opu_unpacker.sv ====
// operand format unpacker: integer extension, floating split, string walk
`timescale 1ns/1ns
// ----------------------------------------
// Overview of operation
// - integer operands come in 8, 16, 32 and 64 bit widths.
// - memory bytes are little endian; lowest address holds bit 0.
// - signed integers are two's complement with the top bit as sign.
// - byte sign is bit 7; unsigned byte covers 0 to 255.
// - word sign is bit 15; unsigned word covers 0 to 65535.
// - longword sign is bit 31; unsigned covers all 32 bits.
// - quadword sign is bit 63, bits 0 to 62 magnitude.
// - memory operands may start at any byte address.
// - register byte in 7:0, word in 15:0; 64-bit uses pair n, n+1.
// - single float: sign bit 15, exponent 14:7, fraction 6:0 and 31:16.
// - exponent is excess 128; fields 1 to 255 give -127 to +127.
// - fraction is 24 bits with hidden leading one, stored 16..31 then 0..6.
// - value is signed fraction in [0.5,1) times two to the exponent.
// - exponent zero with sign zero is the value zero.
// - exponent zero with sign one is a reserved operand.
// - a reserved floating operand raises a fault, no result.
// - double float adds 32 low fraction bits, same sign and exponent rules.
// - double fraction order rising: 48-63, 32-47, 16-31, 0-6.
// - unsigned reading supported for add, subtract and compare.
// - a string is a start address and byte count, rising addresses.
// - string length 0 to 65535; empty string makes no memory access.
// ----------------------------------------
module opu_unpacker (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // operand request
    input wire logic op_valid,
    input wire opu_pkg::opu_kind_e op_kind,
    input wire logic op_signed,
    input wire logic op_from_reg,
    // operand sources
    input wire logic [opu_pkg::OPU_QUAD_W-1:0] mem_bytes,
    input wire logic [opu_pkg::OPU_LONG_W-1:0] general_register_n,
    input wire logic [opu_pkg::OPU_LONG_W-1:0] general_register_n1,
    // integer result
    output logic res_valid,
    output logic res_illegal,
    output logic [opu_pkg::OPU_QUAD_W-1:0] int_value,
    output logic int_negative,
    output logic int_zero,
    // floating result
    output logic flt_valid,
    output logic flt_sign,
    output logic [opu_pkg::OPU_TEXP_W-1:0] flt_true_exp,
    output logic [opu_pkg::OPU_EXP_W-1:0] biased_exponent_field,
    output logic [opu_pkg::OPU_FRAC_W-1:0] flt_fraction,
    output logic flt_zero,
    output logic flt_reserved,
    output logic rsvd_fault,
    // string request
    input wire logic str_start,
    input wire logic [opu_pkg::OPU_ADDR_W-1:0] str_addr,
    input wire logic [opu_pkg::OPU_LEN_W-1:0] str_len,
    input wire logic str_rd_ready,
    // string reads
    output logic str_rd_valid,
    output logic [opu_pkg::OPU_ADDR_W-1:0] str_rd_addr,
    output logic str_busy,
    output logic str_done
);
    import opu_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic res_valid;
        logic res_illegal;
        logic [OPU_QUAD_W-1:0] int_value;
        logic int_negative;
        logic int_zero;
        logic flt_valid;
        logic flt_sign;
        logic [OPU_TEXP_W-1:0] flt_true_exp;
        logic [OPU_EXP_W-1:0] exp_field;
        logic [OPU_FRAC_W-1:0] flt_fraction;
        logic flt_zero;
        logic flt_reserved;
        logic rsvd_fault;
    } opu_state_s;

    opu_state_s st_r;
    opu_state_s st_nxt;

    // ----------------------------------------
    // operand assembly
    // ----------------------------------------
    // memory bytes arrive already ordered by rising address, so byte i
    // of the bus is address a+i; no alignment fix-up is ever needed
    logic [OPU_QUAD_W-1:0] raw_q;
    logic [OPU_LONG_W-1:0] raw_l;

    always_comb begin
        if (op_from_reg) begin
            raw_q = {general_register_n1, general_register_n};
        end else begin
            raw_q = mem_bytes;
        end
        raw_l = raw_q[OPU_LONG_W-1:0];
    end

    // ----------------------------------------
    // integer extension
    // ----------------------------------------
    logic ext_sign;
    logic [OPU_QUAD_W-1:0] ext_value;

    always_comb begin
        ext_sign = 1'b0;
        ext_value = OPU_RST_Q;
        case (op_kind)
            OPU_KIND_BYTE: begin
                ext_sign = op_signed & raw_q[OPU_BYTE_SIGN];
                ext_value = {{(OPU_QUAD_W-OPU_BYTE_W){ext_sign}}, raw_q[OPU_BYTE_W-1:0]};
            end
            OPU_KIND_WORD: begin
                ext_sign = op_signed & raw_q[OPU_WORD_SIGN];
                ext_value = {{(OPU_QUAD_W-OPU_WORD_W){ext_sign}}, raw_q[OPU_WORD_W-1:0]};
            end
            OPU_KIND_LONG: begin
                ext_sign = op_signed & raw_q[OPU_LONG_SIGN];
                ext_value = {{(OPU_QUAD_W-OPU_LONG_W){ext_sign}}, raw_q[OPU_LONG_W-1:0]};
            end
            OPU_KIND_QUAD: begin
                ext_sign = op_signed & raw_q[OPU_QUAD_SIGN];
                ext_value = raw_q;
            end
            default: begin
                ext_sign = 1'b0;
                ext_value = OPU_RST_Q;
            end
        endcase
    end
    // with op_signed low every bit is magnitude and the value is zero extended

    // ----------------------------------------
    // floating decode
    // ----------------------------------------
    logic is_float;
    logic is_double;
    logic f_sign;
    logic [OPU_EXP_W-1:0] f_exp;
    logic [OPU_FRAC_W-1:0] f_frac;
    logic f_zero;
    logic f_rsvd;
    logic [OPU_TEXP_W-1:0] f_texp;

    always_comb begin
        is_float = (op_kind == OPU_KIND_FFLT) || (op_kind == OPU_KIND_DFLT);
        is_double = (op_kind == OPU_KIND_DFLT);
        f_sign = raw_l[OPU_FLT_SIGN];
        f_exp = raw_l[OPU_FLT_EXP_HI:OPU_FLT_EXP_LO];
        if (is_double) begin
            f_frac = {1'b1, raw_q[OPU_FLT_FRA_HI:OPU_FLT_FRA_LO], raw_q[OPU_FLT_FRB_HI:OPU_FLT_FRB_LO],
                      raw_q[OPU_DFL_FRC_HI:OPU_DFL_FRC_LO], raw_q[OPU_DFL_FRD_HI:OPU_DFL_FRD_LO]};
        end else begin
            f_frac = {1'b1, raw_l[OPU_FLT_FRA_HI:OPU_FLT_FRA_LO], raw_l[OPU_FLT_FRB_HI:OPU_FLT_FRB_LO],
                      {(OPU_FRAC_W-OPU_FFRAC_W){1'b0}}};
        end
        f_zero = (f_exp == OPU_EXP_ZERO) && !f_sign;
        f_rsvd = (f_exp == OPU_EXP_ZERO) && f_sign;
        // excess 128: a 10-bit signed difference holds -128 through +127
        f_texp = {2'b00, f_exp} - OPU_EXP_BIAS;
    end
    // leading one restored puts the fraction in [0.5,1)

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.res_valid = 1'b0;
        st_nxt.flt_valid = 1'b0;
        st_nxt.rsvd_fault = 1'b0;
        st_nxt.res_illegal = 1'b0;
        if (op_valid) begin
            st_nxt.res_valid = 1'b1;
            st_nxt.int_value = OPU_RST_Q;
            st_nxt.int_negative = 1'b0;
            st_nxt.int_zero = 1'b0;
            st_nxt.flt_sign = 1'b0;
            st_nxt.flt_true_exp = OPU_RST_TEXP;
            st_nxt.exp_field = OPU_EXP_ZERO;
            st_nxt.flt_fraction = OPU_RST_FRAC;
            st_nxt.flt_zero = 1'b0;
            st_nxt.flt_reserved = 1'b0;
            if (is_float) begin
                st_nxt.exp_field = f_exp;
                if (f_rsvd) begin
                    // no numeric result leaves with a fault
                    st_nxt.flt_reserved = 1'b1;
                    st_nxt.rsvd_fault = 1'b1;
                    st_nxt.flt_sign = f_sign;
                end else if (f_zero) begin
                    // fraction bits of a zero are ignored, value is exactly zero
                    st_nxt.flt_zero = 1'b1;
                    st_nxt.flt_valid = 1'b1;
                end else begin
                    st_nxt.flt_valid = 1'b1;
                    st_nxt.flt_sign = f_sign;
                    st_nxt.flt_true_exp = f_texp;
                    st_nxt.flt_fraction = f_frac;
                end
            end else if (op_kind <= OPU_KIND_QUAD) begin
                st_nxt.int_value = ext_value;
                st_nxt.int_negative = ext_sign;
                st_nxt.int_zero = (ext_value == OPU_RST_Q);
            end else begin
                st_nxt.res_illegal = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r <= '{res_valid: 1'b0, res_illegal: 1'b0, int_value: OPU_RST_Q, int_negative: 1'b0,
                      int_zero: 1'b0, flt_valid: 1'b0, flt_sign: 1'b0, flt_true_exp: OPU_RST_TEXP,
                      exp_field: OPU_EXP_ZERO, flt_fraction: OPU_RST_FRAC, flt_zero: 1'b0,
                      flt_reserved: 1'b0, rsvd_fault: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // string walker
    // ----------------------------------------
    opu_str_if sif ();

    assign sif.start = str_start;
    assign sif.addr = str_addr;
    assign sif.len = str_len;
    assign sif.rd_ready = str_rd_ready;

    opu_str_walker u_walker (
        .clk_sys(clk_sys),
        .rst(rst),
        .sif(sif)
    );

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign res_valid = st_r.res_valid;
    assign res_illegal = st_r.res_illegal;
    assign int_value = st_r.int_value;
    assign int_negative = st_r.int_negative;
    assign int_zero = st_r.int_zero;
    assign flt_valid = st_r.flt_valid;
    assign flt_sign = st_r.flt_sign;
    assign flt_true_exp = st_r.flt_true_exp;
    assign biased_exponent_field = st_r.exp_field;
    assign flt_fraction = st_r.flt_fraction;
    assign flt_zero = st_r.flt_zero;
    assign flt_reserved = st_r.flt_reserved;
    assign rsvd_fault = st_r.rsvd_fault;
    assign str_rd_valid = sif.rd_valid;
    assign str_rd_addr = sif.rd_addr;
    assign str_busy = sif.busy;
    assign str_done = sif.done;
endmodule

// ==== opu_pkg.sv ====
// package of constants and types for the operand format unpacker
package opu_pkg;

    // ----------------------------------------
    // operand kinds
    // ----------------------------------------
    typedef enum logic [2:0] {
        OPU_KIND_BYTE = 3'h0,
        OPU_KIND_WORD = 3'h1,
        OPU_KIND_LONG = 3'h2,
        OPU_KIND_QUAD = 3'h3,
        OPU_KIND_FFLT = 3'h4,
        OPU_KIND_DFLT = 3'h5
    } opu_kind_e;

    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int OPU_BYTE_W = 8;
    localparam int OPU_WORD_W = 16;
    localparam int OPU_LONG_W = 32;
    localparam int OPU_QUAD_W = 64;
    localparam int OPU_EXP_W = 8;
    localparam int OPU_TEXP_W = 10;
    localparam int OPU_FRAC_W = 56;
    localparam int OPU_FFRAC_W = 24;
    localparam int OPU_ADDR_W = 32;
    localparam int OPU_LEN_W = 16;

    // ----------------------------------------
    // integer sign positions
    // ----------------------------------------
    localparam int OPU_BYTE_SIGN = 7;
    localparam int OPU_WORD_SIGN = 15;
    localparam int OPU_LONG_SIGN = 31;
    localparam int OPU_QUAD_SIGN = 63;

    // ----------------------------------------
    // floating field positions
    // ----------------------------------------
    localparam int OPU_FLT_SIGN = 15;
    localparam int OPU_FLT_EXP_HI = 14;
    localparam int OPU_FLT_EXP_LO = 7;
    localparam int OPU_FLT_FRA_HI = 6;
    localparam int OPU_FLT_FRA_LO = 0;
    localparam int OPU_FLT_FRB_HI = 31;
    localparam int OPU_FLT_FRB_LO = 16;
    localparam int OPU_DFL_FRC_HI = 47;
    localparam int OPU_DFL_FRC_LO = 32;
    localparam int OPU_DFL_FRD_HI = 63;
    localparam int OPU_DFL_FRD_LO = 48;

    // ----------------------------------------
    // floating constants and reset values
    // ----------------------------------------
    localparam logic [OPU_TEXP_W-1:0] OPU_EXP_BIAS = 10'h080;
    localparam logic [OPU_EXP_W-1:0] OPU_EXP_ZERO = 8'h00;
    localparam logic [OPU_QUAD_W-1:0] OPU_RST_Q = 64'h0000000000000000;
    localparam logic [OPU_FRAC_W-1:0] OPU_RST_FRAC = 56'h00000000000000;
    localparam logic [OPU_TEXP_W-1:0] OPU_RST_TEXP = 10'h000;
    localparam logic [OPU_ADDR_W-1:0] OPU_RST_ADDR = 32'h00000000;
    localparam logic [OPU_LEN_W-1:0] OPU_RST_LEN = 16'h0000;
    localparam logic [OPU_LEN_W-1:0] OPU_LEN_ONE = 16'h0001;
    localparam logic [OPU_ADDR_W-1:0] OPU_ADDR_STEP = 32'h00000001;

endpackage

// ==== opu_str_if.sv ====
// interface between the unpacker top and its string address walker
`timescale 1ns/1ns
interface opu_str_if;
    import opu_pkg::*;
    logic start;
    logic [OPU_ADDR_W-1:0] addr;
    logic [OPU_LEN_W-1:0] len;
    logic rd_ready;
    logic rd_valid;
    logic [OPU_ADDR_W-1:0] rd_addr;
    logic busy;
    logic done;

    modport walker (
        input start, addr, len, rd_ready,
        output rd_valid, rd_addr, busy, done
    );
    modport client (
        output start, addr, len, rd_ready,
        input rd_valid, rd_addr, busy, done
    );
endinterface

// ==== opu_str_walker.sv ====
// character string walker: one byte address per accepted read
`timescale 1ns/1ns
module opu_str_walker (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // string port
    opu_str_if.walker sif
);
    import opu_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic busy;
        logic rd_valid;
        logic [OPU_ADDR_W-1:0] addr;
        logic [OPU_LEN_W-1:0] remain;
        logic done;
    } opu_walk_s;

    opu_walk_s st_r;
    opu_walk_s st_nxt;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        if (!st_r.busy) begin
            // a start while busy is ignored, so the live string is never cut short
            if (sif.start) begin
                if (sif.len == OPU_RST_LEN) begin
                    st_nxt.done = 1'b1;
                end else begin
                    st_nxt.busy = 1'b1;
                    st_nxt.rd_valid = 1'b1;
                    st_nxt.addr = sif.addr;
                    st_nxt.remain = sif.len;
                end
            end
        end else if (st_r.rd_valid && sif.rd_ready) begin
            if (st_r.remain == OPU_LEN_ONE) begin
                st_nxt.busy = 1'b0;
                st_nxt.rd_valid = 1'b0;
                st_nxt.remain = OPU_RST_LEN;
                st_nxt.done = 1'b1;
            end else begin
                st_nxt.addr = st_r.addr + OPU_ADDR_STEP;
                st_nxt.remain = st_r.remain - OPU_LEN_ONE;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_r <= '{busy: 1'b0, rd_valid: 1'b0, addr: OPU_RST_ADDR, remain: OPU_RST_LEN, done: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sif.busy = st_r.busy;
    assign sif.rd_valid = st_r.rd_valid;
    assign sif.rd_addr = st_r.addr;
    assign sif.done = st_r.done;
endmodule

// ==== opu_unpacker_assertions.sv ====
// concurrent checks on the operand format unpacker ports
`timescale 1ns/1ns
module opu_unpacker_assertions (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // operand request
    input wire logic op_valid,
    input wire opu_pkg::opu_kind_e op_kind,
    input wire logic op_signed,
    input wire logic op_from_reg,
    input wire logic [opu_pkg::OPU_QUAD_W-1:0] mem_bytes,
    input wire logic [opu_pkg::OPU_LONG_W-1:0] general_register_n,
    input wire logic [opu_pkg::OPU_LONG_W-1:0] general_register_n1,
    // results
    input wire logic res_valid,
    input wire logic [opu_pkg::OPU_QUAD_W-1:0] int_value,
    input wire logic flt_valid,
    input wire logic [opu_pkg::OPU_TEXP_W-1:0] flt_true_exp,
    input wire logic [opu_pkg::OPU_EXP_W-1:0] biased_exponent_field,
    input wire logic [opu_pkg::OPU_FRAC_W-1:0] flt_fraction,
    input wire logic flt_zero,
    input wire logic rsvd_fault,
    // string side
    input wire logic str_start,
    input wire logic [opu_pkg::OPU_LEN_W-1:0] str_len,
    input wire logic str_rd_ready,
    input wire logic str_rd_valid,
    input wire logic [opu_pkg::OPU_ADDR_W-1:0] str_rd_addr,
    input wire logic str_busy,
    input wire logic str_done
);
    import opu_pkg::*;
    logic flt_req;
    // float from memory with a zero exponent field
    assign flt_req = op_valid && !op_from_reg && (op_kind == OPU_KIND_FFLT || op_kind == OPU_KIND_DFLT)
        && mem_bytes[14:7] == OPU_EXP_ZERO;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    answer_latency_a: assert property (op_valid |=> res_valid)
        else $error("no answer one cycle after request");
    answer_cause_a: assert property (res_valid |-> $past(op_valid))
        else $error("answer without request");
    byte_signed_a: assert property (op_valid && op_kind == OPU_KIND_BYTE && op_signed && !op_from_reg
        |=> int_value == {{56{$past(mem_bytes[7])}}, $past(mem_bytes[7:0])}) else $error("byte sign extension");
    word_unsigned_a: assert property (op_valid && op_kind == OPU_KIND_WORD && !op_signed && op_from_reg
        |=> int_value == {48'h0, $past(general_register_n[15:0])}) else $error("word zero extension");
    quad_pair_a: assert property (op_valid && op_kind == OPU_KIND_QUAD && op_from_reg
        |=> int_value == {$past(general_register_n1), $past(general_register_n)}) else $error("register pair order");
    float_zero_a: assert property (flt_req && !mem_bytes[15] |=> flt_zero && flt_valid && !rsvd_fault)
        else $error("zero float not flagged");
    reserved_fault_a: assert property (flt_req && mem_bytes[15] |=> rsvd_fault && !flt_valid)
        else $error("reserved operand without fault");
    true_exp_a: assert property (flt_valid && !flt_zero
        |-> flt_true_exp == {2'h0, biased_exponent_field} - OPU_EXP_BIAS) else $error("exponent bias");
    hidden_one_a: assert property (flt_valid && !flt_zero |-> flt_fraction[OPU_FRAC_W-1])
        else $error("hidden fraction bit missing");
    empty_string_a: assert property (str_start && !str_busy && str_len == OPU_RST_LEN
        |=> str_done && !str_rd_valid) else $error("empty string read memory");
    addr_hold_a: assert property (str_rd_valid && !str_rd_ready |=> str_rd_valid && $stable(str_rd_addr))
        else $error("read address moved while stalled");
    addr_step_a: assert property (str_rd_valid && str_rd_ready
        |=> !str_rd_valid || str_rd_addr == $past(str_rd_addr) + OPU_ADDR_STEP) else $error("address step");
    walk_end_a: assert property ($fell(str_busy) |-> str_done)
        else $error("walk ended without done");
endmodule
bind opu_unpacker opu_unpacker_assertions opu_unpacker_assertions_i (.clk_sys, .rst, .op_valid, .op_kind,
    .op_signed, .op_from_reg, .mem_bytes, .general_register_n, .general_register_n1, .res_valid, .int_value,
    .flt_valid, .flt_true_exp, .biased_exponent_field, .flt_fraction, .flt_zero, .rsvd_fault, .str_start,
    .str_len, .str_rd_ready, .str_rd_valid, .str_rd_addr, .str_busy, .str_done);

// ==== opu_str_consumer.sv ====
// byte fetch model that takes string read addresses
`timescale 1ns/1ns
module opu_str_consumer (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // read side
    input wire logic slow,
    input wire logic rd_valid,
    input wire logic [opu_pkg::OPU_ADDR_W-1:0] rd_addr,
    output logic rd_ready,
    // record of accepted reads
    output logic [opu_pkg::OPU_ADDR_W-1:0] last_addr,
    output int taken
);
    logic phase = 1'b0;
    initial begin
        rd_ready = 1'b0;
        last_addr = 32'h0;
        taken = 0;
    end
    // every accepted address is one byte fetched; empty strings must add none
    always @(posedge clk_sys) begin
        if (!rst && rd_valid && rd_ready) begin
            last_addr <= rd_addr;
            taken <= taken + 1;
        end
        phase <= ~phase;
    end
    // slow mode stalls every other cycle to exercise address hold
    always @(posedge clk_sys) begin
        #1;
        rd_ready = ~slow | phase;
    end
endmodule

// ==== opu_unpacker_test.sv ====
// self-checking bench for the operand format unpacker
`timescale 1ns/1ns
module opu_unpacker_test;
    import opu_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic op_valid = 1'b0, op_signed = 1'b0, op_from_reg = 1'b0;
    opu_kind_e op_kind = OPU_KIND_BYTE;
    logic [63:0] mem_bytes = 64'h0, int_value;
    logic [31:0] reg_n = 32'h0, reg_n1 = 32'h0, str_addr = 32'h0, rd_addr, last_addr;
    logic res_valid, res_illegal, int_negative, int_zero, flt_valid, flt_sign, flt_zero, flt_reserved, rsvd_fault;
    logic [9:0] flt_true_exp;
    logic [7:0] exp_field;
    logic [55:0] flt_fraction;
    logic str_start = 1'b0, slow = 1'b0, rd_ready, rd_valid, str_busy, str_done;
    logic [15:0] str_len = 16'h0;
    int taken, errors = 0, tests_run = 0;

    opu_unpacker opu_unpacker_i (.clk_sys(clk_sys), .rst(rst), .op_valid(op_valid), .op_kind(op_kind),
        .op_signed(op_signed), .op_from_reg(op_from_reg), .mem_bytes(mem_bytes), .general_register_n(reg_n),
        .general_register_n1(reg_n1), .res_valid(res_valid), .res_illegal(res_illegal), .int_value(int_value),
        .int_negative(int_negative), .int_zero(int_zero), .flt_valid(flt_valid), .flt_sign(flt_sign),
        .flt_true_exp(flt_true_exp), .biased_exponent_field(exp_field), .flt_fraction(flt_fraction),
        .flt_zero(flt_zero), .flt_reserved(flt_reserved), .rsvd_fault(rsvd_fault), .str_start(str_start),
        .str_addr(str_addr), .str_len(str_len), .str_rd_ready(rd_ready), .str_rd_valid(rd_valid),
        .str_rd_addr(rd_addr), .str_busy(str_busy), .str_done(str_done));
    opu_str_consumer opu_str_consumer_i (.clk_sys(clk_sys), .rst(rst), .slow(slow), .rd_valid(rd_valid),
        .rd_addr(rd_addr), .rd_ready(rd_ready), .last_addr(last_addr), .taken(taken));

    always #5 clk_sys = ~clk_sys;

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic op(input opu_kind_e k, input logic s, input logic r, input logic [63:0] m);
        @(posedge clk_sys);
        #1;
        op_kind = k;
        op_signed = s;
        op_from_reg = r;
        mem_bytes = m;
        op_valid = 1'b1;
        @(posedge clk_sys);
        #1;
        op_valid = 1'b0;
        check("res_valid", 64'(res_valid), 64'h1);
    endtask

    task automatic int_widths();
        logic [63:0] m, mask;
        m = 64'hF1E2D3C4B5A69788;
        for (int k = 0; k < 4; k++) begin
            for (int s = 0; s < 2; s++) begin
                mask = (k == 3) ? 64'hFFFFFFFFFFFFFFFF : (64'h1 << (8 << k)) - 64'h1;
                op(opu_kind_e'(k), s[0], 1'b0, m);
                check("int_value", int_value, (s == 1) ? (m | ~mask) : (m & mask));
                check("int_negative", 64'(int_negative), 64'(s == 1));
            end
        end
        op(OPU_KIND_WORD, 1'b1, 1'b0, 64'hFFFFFFFFFFFF0000);
        check("int_zero", 64'(int_zero), 64'h1);
    endtask

    task automatic reg_operands();
        reg_n = 32'h1234FFFE;
        reg_n1 = 32'h80000001;
        op(OPU_KIND_WORD, 1'b0, 1'b1, 64'h0);
        check("word_reg", int_value, 64'h000000000000FFFE);
        op(OPU_KIND_BYTE, 1'b1, 1'b1, 64'h0);
        check("byte_reg", int_value, 64'hFFFFFFFFFFFFFFFE);
        op(OPU_KIND_QUAD, 1'b1, 1'b1, 64'h0);
        check("quad_reg", int_value, 64'h800000011234FFFE);
        op(opu_kind_e'(3'h6), 1'b0, 1'b0, 64'h5A);
        check("illegal", 64'(res_illegal), 64'h1);
        check("illegal_data", int_value, 64'h0);
    endtask

    // fraction expectation rebuilt from field positions with the hidden bit restored
    task automatic flt_case(input opu_kind_e k, input logic [63:0] m, input logic [9:0] texp);
        op(k, 1'b0, 1'b0, m);
        check("flt_valid", 64'(flt_valid), 64'h1);
        check("flt_sign", 64'(flt_sign), 64'(m[15]));
        check("exp_field", 64'(exp_field), 64'(m[14:7]));
        check("true_exp", 64'(flt_true_exp), 64'(texp));
        check("fraction", 64'(flt_fraction), 64'({1'b1, m[6:0], m[31:16],
            (k == OPU_KIND_DFLT) ? {m[47:32], m[63:48]} : 32'h0}));
    endtask

    task automatic zero_reserved();
        for (int d = 0; d < 2; d++) begin
            op(opu_kind_e'(3'h4 + d[2:0]), 1'b0, 1'b0, 64'h123456789ABC007F);
            check("zero_flags", 64'({flt_zero, flt_valid, rsvd_fault}), 64'h6);
            check("zero_frac", 64'(flt_fraction), 64'h0);
            op(opu_kind_e'(3'h4 + d[2:0]), 1'b0, 1'b0, 64'h123456789ABC807F);
            check("rsvd_flags", 64'({flt_reserved, flt_valid, rsvd_fault}), 64'h5);
            check("rsvd_sign", 64'(flt_sign), 64'h1);
        end
    endtask

    // poke raises a second start mid-walk, which must be ignored
    task automatic walk(input logic [31:0] a, input logic [15:0] n, input logic s, input logic poke);
        int t0;
        int i;
        t0 = taken;
        slow = s;
        @(posedge clk_sys);
        #1;
        str_addr = a;
        str_len = n;
        str_start = 1'b1;
        i = 0;
        while (!str_done && i < 200) begin
            @(posedge clk_sys);
            #1;
            str_start = poke && i == 2;
            if (str_start) begin
                str_addr = 32'h0;
            end
            i++;
        end
        str_start = 1'b0;
        check("done", 64'(str_done), 64'h1);
        check("idle", 64'(str_busy), 64'h0);
        check("count", 64'(taken - t0), 64'(n));
        if (n != 16'h0) begin
            check("last_addr", 64'(last_addr), 64'(a + 32'(n) - 32'h1));
        end
        @(posedge clk_sys);
        #1;
        check("done_pulse", 64'(str_done), 64'h0);
    endtask

    initial begin
        repeat (20) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        int_widths();
        reg_operands();
        flt_case(OPU_KIND_FFLT, 64'h0000000000004080, 10'h001);
        flt_case(OPU_KIND_FFLT, 64'hFFFFFFFFABCD407F, 10'h000);
        flt_case(OPU_KIND_FFLT, 64'h0000000000008080, 10'h381);
        flt_case(OPU_KIND_DFLT, 64'h11223344556640FF, 10'h001);
        zero_reserved();
        walk(32'h00000100, 16'h2, 1'b0, 1'b0);
        walk(32'h00000FFE, 16'h5, 1'b1, 1'b1);
        walk(32'h12345678, 16'h0, 1'b0, 1'b0);
        results();
    end

    // whole run is well under a thousand cycles
    initial begin
        #100000;
        errors++;
        results();
    end
endmodule
